// *** hw/kr_training_cfg_port_bridge.sv ***
// Purpose: Bridge from training access strobe to core management registers
//          or the transceiver configuration port, with arbiter handshake.
// Assumes: All inputs except the strobe are from the clk_sys_i domain.
// Notes:   Management registers are a local file of 65536 16-bit words.
`include "kr_bridge_map.svh"
`timescale 1ns/1ps
`default_nettype none

module kr_training_cfg_port_bridge #(
    parameter bit HAS_MGMT = 1'b1
) (
    input  wire logic                      clk_sys_i,
    input  wire logic                      rst_i,
    input  wire logic                      trn_strobe_i,
    input  wire kr_bridge_pkg::trn_req_t   trn_req_i,
    input  wire logic [`CFG_DATA_W-1:0]    trn_wdata_i,
    output logic [`CFG_DATA_W-1:0]         trn_rdata_o,
    output logic                           trn_rdack_o,
    output logic                           trn_wrack_o,
    output logic                           cfg_req_o,
    input  wire logic                      cfg_gnt_i,
    output kr_bridge_pkg::cfg_req_t        core_side_bundle_o,
    input  wire kr_bridge_pkg::cfg_rsp_t   core_side_bundle_i,
    input  wire kr_bridge_pkg::cfg_req_t   xcvr_side_bundle_i,
    output kr_bridge_pkg::cfg_req_t        xcvr_port_o,
    input  wire kr_bridge_pkg::cfg_rsp_t   xcvr_port_i,
    output kr_bridge_pkg::cfg_rsp_t        xcvr_side_bundle_o
);
    kr_bridge_pkg::bridge_state_t state_r;
    logic [2:0]                   strobe_sync_r;
    logic                         strobe_seen_r;
    logic                         start;
    logic                         to_mgmt;
    logic [`MGMT_CNT_W-1:0]       mgmt_cnt_r;
    logic [`CFG_DATA_W-1:0]       mgmt_mem_r [0:(1<<`TRN_DEVAD_LO)-1];
    logic [`CFG_DATA_W-1:0]       mgmt_rd_r;
    logic                         done_rnw_r;

    // Decides whether an access goes to the local management file
    function automatic logic pick_mgmt(input kr_bridge_pkg::trn_req_t r);
        // core select only counts with management block
        pick_mgmt = HAS_MGMT && r.core_sel && !r.xcvr_sel;
    endfunction

    // Register index inside the management file
    function automatic logic [`CFG_ADDR_W-1:0] reg_index(input kr_bridge_pkg::trn_req_t r);
        reg_index = r.addr[`TRN_REG_HI:0];
    endfunction

    // Strobe is asynchronous; a level counts once stages two and three agree
    // edge on synchronised strobe
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            strobe_sync_r <= 3'h0;
            strobe_seen_r <= 1'b0;
        end else begin
            strobe_sync_r <= {strobe_sync_r[1:0], trn_strobe_i};
            if (strobe_sync_r[2] == strobe_sync_r[1]) begin
                strobe_seen_r <= strobe_sync_r[2];
            end
        end
    end

    // A strobe that rises while busy is lost, not queued
    // one access per strobe, only when idle
    assign start   = (strobe_sync_r[2] == strobe_sync_r[1]) && strobe_sync_r[2] && !strobe_seen_r
                     && (state_r == kr_bridge_pkg::ST_IDLE);
    // Both selects set: the transceiver takes the access
    // both targets reachable
    assign to_mgmt = pick_mgmt(trn_req_i);

    // Access sequencer
    // single clock domain
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            state_r    <= kr_bridge_pkg::ST_IDLE;
            mgmt_cnt_r <= '0;
            done_rnw_r <= 1'b0;
        end else begin
            case (state_r)
                kr_bridge_pkg::ST_IDLE: begin
                    // Access with no usable select falls through unanswered
                    if (start && to_mgmt) begin
                        state_r    <= kr_bridge_pkg::ST_MGMT;
                        mgmt_cnt_r <= `MGMT_RD_LAT;
                    end else if (start && trn_req_i.xcvr_sel) begin
                        state_r <= kr_bridge_pkg::ST_REQ;
                    end
                    done_rnw_r <= trn_req_i.rnw;
                end
                kr_bridge_pkg::ST_REQ: begin
                    if (cfg_gnt_i) begin
                        state_r <= kr_bridge_pkg::ST_WAIT;
                    end
                end
                kr_bridge_pkg::ST_WAIT: begin
                    if (core_side_bundle_i.rdy) begin
                        state_r <= kr_bridge_pkg::ST_DONE;
                    end
                end
                kr_bridge_pkg::ST_MGMT: begin
                    if (mgmt_cnt_r == '0) begin
                        state_r <= kr_bridge_pkg::ST_DONE;
                    end
                    // Wraps after zero; reloaded by the next access
                    mgmt_cnt_r <= mgmt_cnt_r - `MGMT_CNT_W'(1);
                end
                kr_bridge_pkg::ST_DONE: begin
                    // Acks rise on the edge that leaves this state
                    state_r <= kr_bridge_pkg::ST_IDLE;
                end
                default: begin
                    state_r <= kr_bridge_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // request held from start until ready
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            cfg_req_o <= 1'b0;
        end else if (state_r == kr_bridge_pkg::ST_IDLE) begin
            cfg_req_o <= start && !to_mgmt && trn_req_i.xcvr_sel;
        end else if (state_r == kr_bridge_pkg::ST_WAIT && core_side_bundle_i.rdy) begin
            cfg_req_o <= 1'b0;
        end
    end

    // core side strobe one cycle after grant
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            core_side_bundle_o <= '0;
        end else begin
            core_side_bundle_o.en <= (state_r == kr_bridge_pkg::ST_REQ) && cfg_gnt_i;
            core_side_bundle_o.we <= (state_r == kr_bridge_pkg::ST_REQ) && cfg_gnt_i && !trn_req_i.rnw;
            if (state_r == kr_bridge_pkg::ST_REQ) begin
                // low sixteen bits are the register
                core_side_bundle_o.addr  <= reg_index(trn_req_i);
                core_side_bundle_o.wdata <= trn_wdata_i;
            end
        end
    end

    // management file cleared by master reset
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            for (int i = 0; i < (1 << `TRN_DEVAD_LO); i++) begin
                mgmt_mem_r[i] <= `ZERO16;
            end
            mgmt_rd_r <= `ZERO16;
        end else if (start && to_mgmt) begin
            if (!trn_req_i.rnw && trn_req_i.addr[`TRN_DEVAD_HI:`TRN_DEVAD_LO] != `ZERO5) begin
                mgmt_mem_r[reg_index(trn_req_i)] <= trn_wdata_i;
            end
            mgmt_rd_r <= mgmt_mem_r[reg_index(trn_req_i)];
        end
    end

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            trn_rdata_o <= `ZERO16;
            trn_rdack_o <= 1'b0;
            trn_wrack_o <= 1'b0;
        end else begin
            trn_rdack_o <= (state_r == kr_bridge_pkg::ST_DONE) && done_rnw_r;
            trn_wrack_o <= (state_r == kr_bridge_pkg::ST_DONE) && !done_rnw_r;
            if (state_r == kr_bridge_pkg::ST_WAIT && core_side_bundle_i.rdy && done_rnw_r) begin
                trn_rdata_o <= core_side_bundle_i.rdata;
            end else if (state_r == kr_bridge_pkg::ST_MGMT && mgmt_cnt_r == '0 && done_rnw_r) begin
                trn_rdata_o <= mgmt_rd_r;
            end
        end
    end

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            xcvr_port_o <= '0;
        end else begin
            xcvr_port_o <= xcvr_side_bundle_i;
        end
    end

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            xcvr_side_bundle_o <= '0;
        end else begin
            xcvr_side_bundle_o <= xcvr_port_i;
        end
    end
endmodule
`default_nettype wire

// *** common/kr_bridge_map.svh ***
// Purpose: Named constants for the training access bridge.
// Assumes: Management/configuration clock at 25 MHz.
// Notes:   Definitions only.
`ifndef KR_BRIDGE_MAP_SVH
`define KR_BRIDGE_MAP_SVH
`define TRN_ADDR_W      21
`define TRN_DEVAD_HI    20
`define TRN_DEVAD_LO    16
`define TRN_REG_HI      15
`define CFG_DATA_W      16
`define CFG_ADDR_W      16
`define ZERO16          16'h0000
`define ZERO5           5'h00
`define MGMT_CNT_W      2
`define MGMT_RD_LAT     2'h1
`endif

// *** common/kr_bridge_pkg.sv ***
// Purpose: Types for the training access bridge.
// Assumes: Constants come from kr_bridge_map.svh.
// Notes:   Bundles travel as packed structs.
`include "kr_bridge_map.svh"
package kr_bridge_pkg;
    typedef struct packed {
        logic [`CFG_ADDR_W-1:0] addr;
        logic [`CFG_DATA_W-1:0] wdata;
        logic                   en;
        logic                   we;
    } cfg_req_t;

    typedef struct packed {
        logic [`CFG_DATA_W-1:0] rdata;
        logic                   rdy;
    } cfg_rsp_t;

    typedef struct packed {
        logic [`TRN_ADDR_W-1:0] addr;
        logic                   rnw;
        logic                   core_sel;
        logic                   xcvr_sel;
    } trn_req_t;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_REQ   = 3'b001,
        ST_WAIT  = 3'b011,
        ST_MGMT  = 3'b100,
        ST_DONE  = 3'b010
    } bridge_state_t;
endpackage

// *** testbench/kr_bridge_assertions.sv ***
// Purpose: Port checks for the training bridge
// Assumes: One clock domain
// Notes:   Bound to the bridge top
`include "kr_bridge_map.svh"
`timescale 1ns/1ps
`default_nettype none
module kr_bridge_chk (
    input wire logic                    clk_sys_i,
    input wire logic                    rst_i,
    input wire logic [`CFG_DATA_W-1:0]  trn_rdata_o,
    input wire logic                    trn_rdack_o,
    input wire logic                    trn_wrack_o,
    input wire logic                    cfg_req_o,
    input wire logic                    cfg_gnt_i,
    input wire kr_bridge_pkg::cfg_req_t core_side_bundle_o,
    input wire kr_bridge_pkg::cfg_rsp_t core_side_bundle_i,
    input wire kr_bridge_pkg::cfg_req_t xcvr_side_bundle_i,
    input wire kr_bridge_pkg::cfg_req_t xcvr_port_o,
    input wire kr_bridge_pkg::cfg_rsp_t xcvr_port_i,
    input wire kr_bridge_pkg::cfg_rsp_t xcvr_side_bundle_o
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);
    property p_pass_req; !$past(rst_i) |-> xcvr_port_o == $past(xcvr_side_bundle_i); endproperty
    a_pass_req: assert property (p_pass_req) else $error("request pass-through");
    property p_pass_rsp; !$past(rst_i) |-> xcvr_side_bundle_o == $past(xcvr_port_i); endproperty
    a_pass_rsp: assert property (p_pass_rsp) else $error("response pass-through");
    property p_ack_excl; !(trn_rdack_o && trn_wrack_o); endproperty
    a_ack_excl: assert property (p_ack_excl) else $error("both acks");
    property p_rdack; trn_rdack_o |=> !trn_rdack_o; endproperty
    a_rdack: assert property (p_rdack) else $error("read ack length");
    property p_wrack; trn_wrack_o |=> !trn_wrack_o; endproperty
    a_wrack: assert property (p_wrack) else $error("write ack length");
    property p_ack_idle; (trn_rdack_o || trn_wrack_o) |-> !cfg_req_o && !core_side_bundle_o.en; endproperty
    a_ack_idle: assert property (p_ack_idle) else $error("ack while port busy");
    property p_en_owned; core_side_bundle_o.en |-> cfg_req_o && $past(cfg_gnt_i); endproperty
    a_en_owned: assert property (p_en_owned) else $error("port used without grant");
    property p_one_txn; core_side_bundle_o.en |=> (!core_side_bundle_o.en) [*2]; endproperty
    a_one_txn: assert property (p_one_txn) else $error("second transaction");
    property p_req_drop; $fell(cfg_req_o) |-> $past(core_side_bundle_i.rdy); endproperty
    a_req_drop: assert property (p_req_drop) else $error("request dropped early");
    property p_rdata; $changed(trn_rdata_o) |=> trn_rdack_o; endproperty
    a_rdata: assert property (p_rdata) else $error("read word without ack");
endmodule
bind kr_training_cfg_port_bridge kr_bridge_chk u_chk (.*);
`default_nettype wire

// *** testbench/kr_cfg_partner.sv ***
// Purpose: Arbiter and transceiver port model
// Assumes: lat_i sets ready delay
// Notes:   Data rolls when not ready
`timescale 1ns/1ps
`default_nettype none
module kr_cfg_partner (
    input wire logic                    clk_sys_i,
    input wire logic                    rst_i,
    input wire logic                    cfg_req_o,
    input wire logic [3:0]              lat_i,
    input wire kr_bridge_pkg::cfg_req_t core_side_bundle_o,
    output logic                        cfg_gnt_i,
    output kr_bridge_pkg::cfg_rsp_t     core_side_bundle_i
);
    logic [15:0] mem [0:255];
    logic [7:0]  a;
    logic [4:0]  cnt;
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            cfg_gnt_i <= 1'b0;
            core_side_bundle_i <= '0;
            cnt <= 5'h00;
        end else begin
            cfg_gnt_i <= cfg_req_o;
            core_side_bundle_i.rdy <= 1'b0;
            core_side_bundle_i.rdata <= ~core_side_bundle_i.rdata;
            if (core_side_bundle_o.en) begin
                cnt <= {1'b0, lat_i} + 5'h01;
                a <= core_side_bundle_o.addr[7:0];
                if (core_side_bundle_o.we)
                    mem[core_side_bundle_o.addr[7:0]] <= core_side_bundle_o.wdata;
            end else if (cnt == 5'h01) begin
                core_side_bundle_i <= {mem[a], 1'b1};
                cnt <= 5'h00;
            end else if (cnt != 5'h00)
                cnt <= cnt - 5'h01;
        end
    end
endmodule
`default_nettype wire

// *** testbench/kr_training_cfg_port_bridge_tb.sv ***
// Purpose: Self-checking bench for the bridge
// Assumes: 25 MHz clock
// Notes:   Expected acks queue in order
`timescale 1ns/1ps
`default_nettype none
module kr_training_cfg_port_bridge_tb;
    logic clk_sys_i = 0, rst_i = 1, strb = 0, gnt, rda, wra, req;
    logic [15:0] wd = 0, rd, d;
    logic [3:0] lat = 0;
    kr_bridge_pkg::trn_req_t rq = '0;
    kr_bridge_pkg::cfg_req_t cq, xq = '0, xpo;
    kr_bridge_pkg::cfg_rsp_t cr, xr = '0, xso;
    logic [16:0] q[$];
    int n_mismatch = 0, checked = 0;
    // any valid rate, 40 ns here
    initial forever #20 clk_sys_i = ~clk_sys_i;
    kr_training_cfg_port_bridge uut (.clk_sys_i, .rst_i, .trn_strobe_i(strb), .trn_req_i(rq), .trn_wdata_i(wd),
        .trn_rdata_o(rd), .trn_rdack_o(rda), .trn_wrack_o(wra), .cfg_req_o(req), .cfg_gnt_i(gnt),
        .core_side_bundle_o(cq), .core_side_bundle_i(cr), .xcvr_side_bundle_i(xq), .xcvr_port_o(xpo),
        .xcvr_port_i(xr), .xcvr_side_bundle_o(xso));
    kr_cfg_partner pm (.clk_sys_i, .rst_i, .cfg_req_o(req), .lat_i(lat), .core_side_bundle_o(cq),
        .cfg_gnt_i(gnt), .core_side_bundle_i(cr));
    task automatic report_and_stop;
        $display("mismatches %0d checks %0d", n_mismatch, checked);
        if (n_mismatch == 0 && checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic cmp(input logic [16:0] g, input logic [16:0] e);
        checked++;
        if (g !== e) begin
            n_mismatch++;
            $display("mismatch t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic acc(input logic [20:0] a, input logic [2:0] sel, input logic [15:0] dw, input logic ack,
                       input logic [16:0] e);
        int i;
        @(posedge clk_sys_i);
        rq <= {a, sel};
        wd <= dw;
        strb <= 1;
        if (ack) q.push_back(e);
        for (i = 0; i < 60 && !(ack && (rda || wra)); i++) @(posedge clk_sys_i);
        if (ack && i == 60) begin
            n_mismatch++;
            report_and_stop();
        end
        strb <= 0;
        rq <= '0;
        repeat (4) @(posedge clk_sys_i);
    endtask
    always @(posedge clk_sys_i) begin
        xq <= 34'({$urandom, $urandom});
        xr <= 17'($urandom);
        if (!rst_i && (rda || wra)) begin
            if (q.size() == 0) cmp({rda, wra, 15'h0000}, 17'h0_0000);
            else cmp(rda ? {1'b1, rd} : 17'h0_0000, q.pop_front());
        end
    end
    initial begin
        void'($urandom(32'h8302));
        repeat (6) @(posedge clk_sys_i);
        rst_i <= 0;
        for (int k = 0; k < 4; k++) begin
            lat <= 4'(k * 4);
            d = 16'($urandom);
            acc(21'(k), 3'b001, d, 1, 17'h0_0000);
            acc(21'(k), 3'b101, 16'h0000, 1, {1'b1, d});
        end
        acc(21'h0_0009, 3'b011, 16'h5a5a, 1, 17'h0_0000);
        acc(21'h0_0009, 3'b101, 16'h0000, 1, 17'h1_5a5a);
        acc(21'h1_0005, 3'b010, 16'hc3a1, 1, 17'h0_0000);
        acc(21'h1_0005, 3'b110, 16'h0000, 1, 17'h1_c3a1);
        acc(21'h0_0006, 3'b010, 16'h7777, 1, 17'h0_0000);
        acc(21'h3_0006, 3'b110, 16'h0000, 1, 17'h1_0000);
        acc(21'h1_0005, 3'b100, 16'h0000, 0, 17'h0_0000);
        rst_i <= 1;
        repeat (2) @(posedge clk_sys_i);
        rst_i <= 0;
        acc(21'h1_0005, 3'b110, 16'h0000, 1, 17'h1_0000);
        cmp(17'(q.size()), 17'h0_0000);
        report_and_stop();
    end
endmodule
`default_nettype wire
